// *** rtl/acc_pkg.sv ***
// package for the converter clock and conversion control block
// assumes a 40 MHz system clock that also stands for the cpu clock
package acc_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ACC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ACC_RESULT_OFS = 8'h04;
    localparam logic [7:0] ACC_ISTAT_OFS = 8'h08;
    localparam logic [7:0] ACC_IMASK_OFS = 8'h0c;

    // control register layout and reset value
    localparam int ACC_EN_BIT = 7;
    localparam int ACC_DONE_BIT = 4;
    localparam int ACC_START_BIT = 3;
    localparam int ACC_RC_BIT = 2;
    localparam int ACC_CH_LSB = 0;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;

    // timing of the converter
    localparam int ACC_CLK_KHZ = 40000;
    localparam int ACC_CPU_MAX_KHZ = 20000;
    localparam int ACC_RC_NOM_KHZ = 6000;
    localparam int ACC_RC_TOL_PCT = 25;
    localparam int ACC_CLKS_PER_MC = 6;
    localparam int ACC_CPU_CONV_MC = 31;
    localparam logic [7:0] ACC_CPU_CONV_CLKS =
        8'(ACC_CLKS_PER_MC * ACC_CPU_CONV_MC);
    localparam logic [2:0] ACC_MC_LAST = 3'(ACC_CLKS_PER_MC - 1);
    localparam logic [2:0] ACC_SYNC_MC_MIN = 3'h3;
    localparam logic [2:0] ACC_SYNC_MC_MAX = 3'h4;
    localparam logic [7:0] ACC_RC_CONV_TICKS = 8'h6c;
    localparam logic [7:0] ACC_SAR_SPAN = 8'h40;
    localparam logic [2:0] ACC_SAR_STEP_AT = 3'h7;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_SYNC = 2'b01,
        ACC_CONV = 2'b11
    } acc_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } acc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } acc_apb_rsp_t;

    // word address match, low two bits ignored
    function automatic logic acc_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
        acc_hit = (addr[7:2] == ofs[7:2]);
    endfunction : acc_hit

endpackage : acc_pkg

// *** rtl/acc_sync2.sv ***
// two flip-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clk_i
`timescale 1ns/10ps
module acc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] stage2;
        logic [W-1:0] stage1;
    } acc_sync_t;

    acc_sync_t s;
    acc_sync_t next_s;

    // first stage feeds only the second stage
    always_comb
    begin
        next_s.stage1 = async_i;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign sync_o = s.stage2;
endmodule : acc_sync2

// *** rtl/acc_sar.sv ***
// successive approximation register, one bit decided per step
// assumes comp_i is synchronised and high while input exceeds the trial
`timescale 1ns/10ps
module acc_sar
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic step_i,
    input wire logic comp_i,
    output logic [7:0] code_o
);
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] trial_bit;
    } acc_sar_t;

    acc_sar_t s;
    acc_sar_t next_s;

    // keep or drop the trial bit, then try the next lower one
    always_comb
    begin
        next_s = s;
        if (start_i)
        begin
            next_s.code = 8'h80;
            next_s.trial_bit = 8'h80;
        end
        else if (step_i && (s.trial_bit != 8'h00))
        begin
            next_s.code = (comp_i ? s.code : (s.code & ~s.trial_bit))
                | (s.trial_bit >> 1);
            next_s.trial_bit = s.trial_bit >> 1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign code_o = s.code;
endmodule : acc_sar

// *** rtl/acc_ctrl.sv ***
// converter clock selection, conversion sequencing, apb registers, irq
// assumes clk_i is the cpu clock; rc_osc_i and comp_i are async pins
`timescale 1ns/10ps

// Notes on behaviour
// - reset picks cpu clock for conversions
// - cpu clocked conversion takes 186 clocks
// - works at any cpu clock to maximum
// - rc select bit switches to rc oscillator
// - rc conversion survives power down
// - rc mode syncs for 3 or 4 machine cycles
// - rc conversion spans sync plus 108 rc clocks
// - rc oscillator nominal 6 MHz, 25 percent
// - start bit busy, completion clears it, sets done
// - no start while done flag set
// - channel writes ignored while converting
// - result holds until next completion
module acc_ctrl
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire acc_apb_req_t apb_req_i,
    output acc_apb_rsp_t apb_rsp_o,
    input wire logic rc_osc_i,
    input wire logic comp_i,
    input wire logic power_down_i,
    output logic [7:0] trial_code_o,
    output logic [3:0] input_select_o,
    output logic conv_busy_o,
    output logic irq_o
);
    typedef struct packed {
        acc_state_t st;
        logic enable;
        logic done;
        logic rc_sel;
        logic [1:0] chan;
        logic [7:0] result;
        logic [7:0] cnt;
        logic [2:0] mc_div;
        logic [2:0] sync_mc;
        logic rc_seen;
        logic rc_prev;
        logic irq_stat;
        logic irq_mask;
        logic [31:0] prdata;
    } acc_core_t;

    acc_core_t s;
    acc_core_t next_s;
    logic rc_sync;
    logic comp_sync;
    logic [7:0] sar_code;
    logic sar_start;
    logic sar_step;
    logic done_evt;
    logic wr_access;
    logic [7:0] wd;
    logic mc_tick;
    logic rc_tick;
    logic conv_tick;
    logic [7:0] conv_limit;
    logic new_rc;
    logic start_ok;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and successive approximation engine
    acc_sync2 #(.W(2)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({rc_osc_i, comp_i}),
        .sync_o({rc_sync, comp_sync})
    );

    acc_sar u_sar (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(sar_start),
        .step_i(sar_step),
        .comp_i(comp_sync),
        .code_o(sar_code)
    );

    ////////////////////////////////////////////////////////////////////
    // timing strobes and write decode
    assign wr_access = apb_req_i.psel && apb_req_i.penable
        && apb_req_i.pwrite;
    assign wd = apb_req_i.pwdata[7:0];
    assign mc_tick = (s.mc_div == ACC_MC_LAST);
    assign rc_tick = rc_sync && !s.rc_prev;
    assign conv_tick = s.rc_sel ? rc_tick : 1'b1;
    // first rc edge only opens the count, so 108 whole rc periods pass
    assign conv_limit = s.rc_sel ? ACC_RC_CONV_TICKS + 8'h01
        : ACC_CPU_CONV_CLKS;
    assign new_rc = wd[ACC_RC_BIT];
    assign start_ok = wr_access && acc_hit(apb_req_i.paddr, ACC_CTRL_OFS)
        && wd[ACC_START_BIT] && !s.done && s.enable;

    ////////////////////////////////////////////////////////////////////
    // next state: sequencer, registers, interrupt
    always_comb
    begin
        next_s = s;
        sar_start = 1'b0;
        sar_step = 1'b0;
        done_evt = 1'b0;
        next_s.rc_prev = rc_sync;
        next_s.mc_div = mc_tick ? 3'h0 : s.mc_div + 3'h1;
        unique case (s.st)
            ACC_IDLE:
            begin
                if (start_ok)
                begin
                    next_s.chan = wd[ACC_CH_LSB +: 2];
                    next_s.rc_sel = new_rc;
                    next_s.cnt = 8'h00;
                    next_s.sync_mc = 3'h0;
                    next_s.mc_div = 3'h0; // sync counts whole cycles
                    next_s.rc_seen = 1'b0;
                    sar_start = 1'b1;
                    next_s.st = new_rc ? ACC_SYNC : ACC_CONV;
                end
            end
            ACC_SYNC:
            begin
                if (rc_tick)
                    next_s.rc_seen = 1'b1;
                if (mc_tick)
                begin
                    next_s.sync_mc = s.sync_mc + 3'h1;
                    if ((s.sync_mc + 3'h1 == ACC_SYNC_MC_MAX)
                        || ((s.sync_mc + 3'h1 == ACC_SYNC_MC_MIN)
                        && (s.rc_seen || rc_tick)))
                        next_s.st = ACC_CONV;
                end
            end
            ACC_CONV:
            begin
                if (power_down_i && !s.rc_sel)
                    next_s.st = ACC_IDLE; // cpu clock stops: abort
                else if (conv_tick)
                begin
                    next_s.cnt = s.cnt + 8'h01;
                    sar_step = (s.cnt[2:0] == ACC_SAR_STEP_AT)
                        && (s.cnt < ACC_SAR_SPAN);
                    if (s.cnt + 8'h01 == conv_limit)
                    begin
                        done_evt = 1'b1;
                        next_s.result = sar_code;
                        next_s.st = ACC_IDLE;
                    end
                end
            end
            default:
                next_s.st = ACC_IDLE;
        endcase
        // control writes outside the start path
        if (wr_access && acc_hit(apb_req_i.paddr, ACC_CTRL_OFS))
        begin
            if (s.st == ACC_IDLE && !start_ok)
            begin
                next_s.rc_sel = new_rc;
                if (!s.done)
                    next_s.chan = wd[ACC_CH_LSB +: 2];
            end
            if (s.st == ACC_IDLE && (!s.done || wd[ACC_EN_BIT]))
                next_s.enable = wd[ACC_EN_BIT];
            if (!wd[ACC_DONE_BIT])
                next_s.done = 1'b0;
        end
        // done and irq status: a set in the same cycle wins
        if (wr_access && acc_hit(apb_req_i.paddr, ACC_ISTAT_OFS)
            && wd[0])
            next_s.irq_stat = 1'b0;
        if (wr_access && acc_hit(apb_req_i.paddr, ACC_IMASK_OFS))
            next_s.irq_mask = wd[0];
        if (done_evt)
        begin
            next_s.done = 1'b1;
            next_s.irq_stat = 1'b1;
        end
        // read data captured in the setup phase
        if (apb_req_i.psel && !apb_req_i.penable)
        begin
            next_s.prdata = 32'h0000_0000;
            if (acc_hit(apb_req_i.paddr, ACC_CTRL_OFS))
                next_s.prdata[7:0] = {s.enable, 2'b00, s.done,
                    s.st != ACC_IDLE, s.rc_sel, s.chan};
            else if (acc_hit(apb_req_i.paddr, ACC_RESULT_OFS))
                next_s.prdata[7:0] = s.result;
            else if (acc_hit(apb_req_i.paddr, ACC_ISTAT_OFS))
                next_s.prdata[0] = s.irq_stat;
            else if (acc_hit(apb_req_i.paddr, ACC_IMASK_OFS))
                next_s.prdata[0] = s.irq_mask;
        end
    end

    // all control state resets to the cpu clock, idle
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.rc_sel <= ACC_CTRL_RESET[ACC_RC_BIT];
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign apb_rsp_o.pready = apb_req_i.psel && apb_req_i.penable;
    assign apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable
        && !(acc_hit(apb_req_i.paddr, ACC_CTRL_OFS)
        || acc_hit(apb_req_i.paddr, ACC_RESULT_OFS)
        || acc_hit(apb_req_i.paddr, ACC_ISTAT_OFS)
        || acc_hit(apb_req_i.paddr, ACC_IMASK_OFS));
    assign apb_rsp_o.prdata = s.prdata;
    assign trial_code_o = sar_code;
    assign input_select_o = 4'h1 << s.chan;
    assign conv_busy_o = (s.st != ACC_IDLE);
    assign irq_o = s.irq_stat && s.irq_mask;

    ////////////////////////////////////////////////////////////////////
    // helper counters read only by the checks below
    logic [8:0] conv_len;
    logic [7:0] sync_len;
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            conv_len <= 9'h000;
            sync_len <= 8'h00;
        end
        else
        begin
            conv_len <= (s.st == ACC_CONV) ? conv_len + 9'h001 : 9'h000;
            sync_len <= (s.st == ACC_SYNC) ? sync_len + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence ctrl_write_s;
        wr_access && acc_hit(apb_req_i.paddr, ACC_CTRL_OFS);
    endsequence

    sequence rc_selected_s;
        (s.st != ACC_IDLE) && s.rc_sel;
    endsequence

    rc_sel_write_a: assert property (
        $rose(s.rc_sel) |-> $past(wr_access && new_rc))
        else $error("rc select set without a write");

    cpu_conv_len_a: assert property (
        done_evt && !s.rc_sel |-> conv_len == 9'(ACC_CPU_CONV_CLKS - 1))
        else $error("cpu conversion length wrong");

    rc_sync_len_a: assert property (
        (s.st == ACC_SYNC) && (next_s.st == ACC_CONV)
        |-> sync_len >= 8'(ACC_SYNC_MC_MIN * ACC_CLKS_PER_MC - 1)
        && sync_len <= 8'(ACC_SYNC_MC_MAX * ACC_CLKS_PER_MC - 1))
        else $error("rc sync interval out of range");

    rc_conv_ticks_a: assert property (
        done_evt && s.rc_sel |-> s.cnt == ACC_RC_CONV_TICKS)
        else $error("rc conversion tick count wrong");

    pd_continue_a: assert property (
        rc_selected_s and power_down_i |=> (s.st != ACC_IDLE) || s.done)
        else $error("rc conversion lost in power down");

    done_ends_busy_a: assert property (
        $rose(s.done) |-> (s.st == ACC_IDLE) && $past(s.st != ACC_IDLE))
        else $error("done set without busy ending");

    start_blocked_a: assert property (
        s.done && (s.st == ACC_IDLE) ##0 ctrl_write_s |=> s.st == ACC_IDLE)
        else $error("start taken while done set");

    chan_hold_a: assert property (
        (s.st != ACC_IDLE) ##1 (s.st != ACC_IDLE) |-> $stable(s.chan))
        else $error("channel changed during conversion");

    result_hold_a: assert property (
        $changed(s.result) |-> $rose(s.done))
        else $error("result changed outside completion");

    irq_level_a: assert property (
        irq_o |-> $past(done_evt || s.irq_stat) && s.irq_mask)
        else $error("interrupt without cause");

    cpu_clk_count_a: assert property (
        (s.st == ACC_CONV) && !s.rc_sel && !power_down_i && !done_evt
        |=> s.cnt == $past(s.cnt) + 8'h01)
        else $error("cpu conversion skipped a clock");

endmodule : acc_ctrl

// *** verification/acc_ctrl_tb_top.sv ***
// self-checking bench for the converter clock and conversion control block
// assumes acc_pkg and acc_ctrl are compiled first; comparator is held steady
`timescale 1ns/10ps
module acc_ctrl_tb_top;
    import acc_pkg::*;

    logic clk_i;
    logic reset_i;
    logic rc_osc_i;
    logic comp_i;
    logic power_down_i;
    acc_apb_req_t req;
    acc_apb_rsp_t rsp;
    logic [7:0] trial_code;
    logic [3:0] input_select;
    logic conv_busy;
    logic irq;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int exp_result = 0;

    acc_ctrl acc_ctrl_i (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .apb_req_i(req),
        .apb_rsp_o(rsp),
        .rc_osc_i(rc_osc_i),
        .comp_i(comp_i),
        .power_down_i(power_down_i),
        .trial_code_o(trial_code),
        .input_select_o(input_select),
        .conv_busy_o(conv_busy),
        .irq_o(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clocks: 40 MHz system clock, free running rc oscillator near 6 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial
    begin
        rc_osc_i = 1'b0;
        forever #83 rc_osc_i = ~rc_osc_i;
    end

    // hang guard, far above the fewer than two thousand cycles the run needs
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // report and compare helpers
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                             input string what);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : check_val

    task automatic check_flag(input logic got, input logic exp,
                              input string what);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: flag %s got %b", $time, what, got);
        end
    endtask : check_flag

    // one apb transfer; returns at the edge where pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk_i);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wd;
        @(posedge clk_i);
        req.penable <= 1'b1;
        do @(posedge clk_i); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, wd, d, e);
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h0, d, e);
        check_val(d, exp, "read");
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////
    // start a conversion; mid 1 rewrites channel, mid 2 pulses power down
    task automatic convert(input logic rc, input logic [1:0] ch,
                           input int mid, output int n);
        int t0;
        wr(ACC_CTRL_OFS, 32'h88 | (32'(rc) << 2) | 32'(ch));
        t0 = cycles;
        check_val(input_select, 4'h1 << ch, "select");
        check_flag(conv_busy, 1'b1, "busy");
        if (mid == 1)
        begin
            wr(ACC_CTRL_OFS, 32'h80 | 32'(ch ^ 2'h3));
            check_val(input_select, 4'h1 << ch, "select");
        end
        if (mid == 2)
        begin
            repeat (20) @(posedge clk_i);
            power_down_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            power_down_i <= 1'b0;
        end
        do begin @(posedge clk_i); #1; end
        while (conv_busy === 1'b1 && cycles - t0 < 3000);
        n = cycles - t0;
    endtask : convert

    // completion flags, interrupt, refused restart, done clear, held result
    task automatic finish(input logic rc, input logic [1:0] ch);
        logic [31:0] base;
        base = 32'h80 | (32'(rc) << 2) | 32'(ch);
        rd_chk(ACC_CTRL_OFS, base | 32'h10);
        rd_chk(ACC_RESULT_OFS, 32'(exp_result));
        check_flag(irq, 1'b1, "irq");
        wr(ACC_IMASK_OFS, 32'h0);
        check_flag(irq, 1'b0, "irq masked");
        wr(ACC_IMASK_OFS, 32'h1);
        wr(ACC_CTRL_OFS, 32'h98 | (32'(rc) << 2) | 32'(ch ^ 2'h1));
        check_flag(conv_busy, 1'b0, "restart");
        rd_chk(ACC_CTRL_OFS, base | 32'h10);
        wr(ACC_ISTAT_OFS, 32'h1);
        check_flag(irq, 1'b0, "irq cleared");
        wr(ACC_CTRL_OFS, base);
        rd_chk(ACC_CTRL_OFS, base);
        rd_chk(ACC_RESULT_OFS, 32'(exp_result));
    endtask : finish

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        int n;
        logic comp;
        logic [31:0] d;
        logic e;
        req = '0;
        comp_i = 1'b0;
        power_down_i = 1'b0;
        reset_i = 1'b1;
        void'($urandom(32'h0990));
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        check_val(input_select, 4'h1, "reset select");
        rd_chk(ACC_CTRL_OFS, 32'(ACC_CTRL_RESET));
        rd_chk(ACC_RESULT_OFS, 32'h0);
        apb(1'b0, 8'h10, 32'h0, d, e);
        check_flag(e, 1'b1, "unmapped");
        check_val(d, 32'h0, "unmapped data");
        wr(ACC_RESULT_OFS, 32'h5a);
        rd_chk(ACC_RESULT_OFS, 32'h0);
        wr(ACC_IMASK_OFS, 32'h1);
        // enable first: a start is refused while enable is still low
        wr(ACC_CTRL_OFS, 32'h80);
        rd_chk(ACC_CTRL_OFS, 32'h80);
        // cpu clocked conversions on every channel
        for (int i = 0; i < 4; i++)
        begin
            comp = 1'($urandom_range(1, 0));
            comp_i <= comp;
            exp_result = comp ? 255 : 0;
            convert(1'b0, 2'(i), (i == 1) ? 1 : 0, n);
            check_val(32'(n), 32'(ACC_CLKS_PER_MC * ACC_CPU_CONV_MC),
                      "cpu time");
            finish(1'b0, 2'(i));
        end
        // rc clocked conversion through a power down pulse
        comp = 1'($urandom_range(1, 0));
        comp_i <= comp;
        exp_result = comp ? 255 : 0;
        convert(1'b1, 2'h2, 2, n);
        check_flag(n >= 735 && n <= 771, 1'b1, "rc time");
        finish(1'b1, 2'h2);
        // power down aborts a cpu clocked conversion, result kept
        comp_i <= ~comp;
        convert(1'b0, 2'h3, 2, n);
        check_flag(n < 186, 1'b1, "abort time");
        rd_chk(ACC_CTRL_OFS, 32'h83);
        rd_chk(ACC_RESULT_OFS, 32'(exp_result));
        close_out();
    end

endmodule : acc_ctrl_tb_top
